// *** design/gcsc_clock_control.sv ***
// One clock control block feeding a single global clock network
//
// Function
// - Pins, PLL, dual-purpose, logic sources drive one network
// - Network feeds PLL only from PLL/pin sources
// - Dual-purpose pin source never feeds a PLL
// - Internal logic source never feeds a PLL
// - Only pins and PLL outputs switch at run time
// - Two-bit dynamic select picks the network source
// - Static selects locked during user mode
// - PLL input mux by static or dynamic switch
// - Two PLL taps chosen from four candidates
// - Five PLL outputs, only two reach network
// - Logic enable powers network on or off
// - One corner pin feeds block, other free
// - Unused clock pin becomes fabric-registered input
// - Left side of transceiver part has no pins
// - Five or six blocks per side, 30/20 total
// - Left side of other variant has no pins
// - Smallest parts only have networks 0 to 9
// - Dual-purpose pin is bidirectional control carrier
// - Logic source static only, four inputs dynamic
// - Enable sampled on falling edge of source
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module gcsc_clock_control #(
  parameter int NET_LIMIT = gcsc_pkg::NET_COUNT_GX,
  parameter int NET_INDEX = 0,
  parameter bit LEFT_SIDE = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [1:0] clkPin,
  input wire logic dpIn,
  output logic dpOut,
  output logic dpOe,
  input wire logic [1:0] cornerPin,
  input wire logic [4:0] pllAOut,
  input wire logic [4:0] pllBOut,
  input wire logic logicSrc,
  input wire logic [1:0] dynSel,
  input wire logic netEnable,
  input wire logic clkSwitch,
  input wire logic userMode,
  output logic globalNet,
  output logic pllFeed,
  output logic pllRef,
  output logic [1:0] clkPinGpio,
  output logic cornerGpio,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Device-level network count limits the index of this block
  if (!(NET_LIMIT == gcsc_pkg::NET_COUNT_GX ||
        NET_LIMIT == gcsc_pkg::NET_COUNT_E ||
        NET_LIMIT == gcsc_pkg::NET_COUNT_SMALL)) begin : g_bad_limit
    $error("NET_LIMIT must be 30, 20 or 10");
  end
  // An index past the count would name a network that is absent
  if (NET_INDEX < 0 || NET_INDEX >= NET_LIMIT) begin : g_bad_index
    $error("NET_INDEX outside the network range");
  end

  typedef struct packed {
    logic [gcsc_pkg::SYNC_W-1:0] s1;
    logic [gcsc_pkg::SYNC_W-1:0] s2;
    logic [gcsc_pkg::SYNC_W-1:0] s3;
    logic [gcsc_pkg::SYNC_W-1:0] filt;
    logic [gcsc_pkg::CFG_W-1:0] cfg;
    logic gateEn;
    logic prevSrc;
    logic netOut;
    logic feedOut;
    logic refOut;
    logic [31:0] rdata;
  } gcsc_state_t;

  gcsc_state_t st_reg;
  gcsc_state_t st_next;

  logic [gcsc_pkg::SYNC_W-1:0] rawIn;
  gcsc_pkg::gcsc_mode_t mode;
  logic [1:0] pinLvl;
  logic dualLvl;
  logic tap0;
  logic tap1;
  logic srcLvl;
  logic feedOk;
  logic switchCtl;
  logic access;
  logic setup;
  logic cfgWrite;
  logic hit;
  logic [31:0] readVal;

  // Candidate PLL outputs: two taps from each adjacent PLL
  function automatic logic pllCand(input logic [1:0] idx,
                                   input logic [gcsc_pkg::SYNC_W-1:0] f);
    logic r;
    r = 1'b0;
    unique case (idx)
      2'h0: r = f[gcsc_pkg::PLLA_LSB];
      2'h1: r = f[gcsc_pkg::PLLA_LSB + 1];
      2'h2: r = f[gcsc_pkg::PLLB_LSB];
      2'h3: r = f[gcsc_pkg::PLLB_LSB + 1];
    endcase
    return r;
  endfunction

  // Every external source is treated as asynchronous to core_clk
  assign rawIn = {pllBOut, pllAOut, cornerPin, dpIn, clkPin};

  // Static fields decoded from the configuration register
  assign mode = gcsc_pkg::gcsc_mode_t'(
    st_reg.cfg[gcsc_pkg::MODE_LSB +: 2]);
  // Left-side blocks have no dedicated pins; they read as low
  assign pinLvl = LEFT_SIDE ? 2'h0
                : st_reg.filt[gcsc_pkg::PIN_LSB +: 2];
  // Only the chosen corner pin reaches the block
  assign dualLvl = st_reg.cfg[gcsc_pkg::DP_CORNER]
    ? st_reg.filt[gcsc_pkg::CORNER_LSB
        + int'(st_reg.cfg[gcsc_pkg::CORNER_PICK])]
    : st_reg.filt[gcsc_pkg::DP_BIT];
  // Two taps out of four PLL candidates, the rest never reach here
  assign tap0 = pllCand(st_reg.cfg[gcsc_pkg::PICK0_LSB +: 2],
                        st_reg.filt);
  assign tap1 = pllCand(st_reg.cfg[gcsc_pkg::PICK1_LSB +: 2],
                        st_reg.filt);

  // Source mux; dynamic select only reaches pins and PLL taps
  always_comb begin
    srcLvl = 1'b0;
    unique case (mode)
      gcsc_pkg::MODE_DYN: begin
        unique case (dynSel)
          2'h0: srcLvl = pinLvl[0];
          2'h1: srcLvl = pinLvl[1];
          2'h2: srcLvl = tap0;
          2'h3: srcLvl = tap1;
        endcase
      end
      gcsc_pkg::MODE_DPIN: srcLvl = dualLvl;
      gcsc_pkg::MODE_LOGIC: srcLvl = logicSrc;
      gcsc_pkg::MODE_NONE: srcLvl = 1'b0;
    endcase
  end

  // PLL feed allowed only from dynamic pin or PLL sources
  assign feedOk = (mode == gcsc_pkg::MODE_DYN);

  // With SW_DYNAMIC set, manual switchover overrides the static PLL input choice
  assign switchCtl = st_reg.cfg[gcsc_pkg::SW_DYNAMIC]
                   ? clkSwitch : st_reg.cfg[gcsc_pkg::SW_STATIC];

  // APB phases; the slave never inserts wait states
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign cfgWrite = access && pwrite && (paddr == gcsc_pkg::CFG_OFF);

  // Register read decode with hit flag for unmapped addresses
  always_comb begin
    hit = 1'b1;
    readVal = 32'h0000_0000;
    unique case (paddr)
      gcsc_pkg::CFG_OFF: begin
        readVal[gcsc_pkg::CFG_W-1:0] = st_reg.cfg;
      end
      gcsc_pkg::STATUS_OFF: begin
        readVal[gcsc_pkg::ST_MODE_LSB +: 2] = mode;
        readVal[gcsc_pkg::ST_GATE] = st_reg.gateEn;
        readVal[gcsc_pkg::ST_NET] = st_reg.netOut;
        readVal[gcsc_pkg::ST_FEED_OK] = feedOk;
        readVal[gcsc_pkg::ST_USER] = userMode;
        readVal[gcsc_pkg::ST_REF] = st_reg.refOut;
        readVal[gcsc_pkg::ST_INDEX_LSB +: 5] = 5'(NET_INDEX);
      end
      gcsc_pkg::LEVEL_OFF: begin
        readVal[gcsc_pkg::SYNC_W-1:0] = st_reg.filt;
      end
      default: hit = 1'b0;
    endcase
  end

  // Next-state logic; ce low freezes every flip-flop
  always_comb begin
    st_next = st_reg;
    if (ce) begin
      // Three-stage sync, a change counts once stages two and three agree
      st_next.s1 = rawIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      for (int i = 0; i < gcsc_pkg::SYNC_W; i++) begin
        if (st_reg.s2[i] == st_reg.s3[i]) begin
          st_next.filt[i] = st_reg.s2[i];
        end
      end
      // Static selects writable only before user mode starts
      if (cfgWrite && !userMode) begin
        st_next.cfg = pwdata[gcsc_pkg::CFG_W-1:0];
      end
      // Enable taken only on a falling source edge: no short high phase
      st_next.prevSrc = srcLvl;
      if (st_reg.prevSrc && !srcLvl) begin
        st_next.gateEn = netEnable &&
                         !st_reg.cfg[gcsc_pkg::NET_OFF];
      end
      st_next.netOut = srcLvl && st_reg.gateEn;
      st_next.feedOut = srcLvl && st_reg.gateEn && feedOk;
      st_next.refOut = switchCtl ? pinLvl[1] : pinLvl[0];
      // Read data captured in the setup phase so it comes from a flop
      if (setup) begin
        st_next.rdata = readVal;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.cfg <= gcsc_pkg::CFG_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign globalNet = st_reg.netOut;
  assign pllFeed = st_reg.feedOut;
  assign pllRef = st_reg.refOut;
  // Spare pins read through fabric flops, no pad register
  assign clkPinGpio = pinLvl;
  assign cornerGpio = st_reg.filt[gcsc_pkg::CORNER_LSB
    + int'(!st_reg.cfg[gcsc_pkg::CORNER_PICK])];
  // Pad driver never fights the pin while it is the network source
  assign dpOut = st_reg.cfg[gcsc_pkg::DP_VALUE];
  assign dpOe = st_reg.cfg[gcsc_pkg::DP_DRIVE] &&
    !(mode == gcsc_pkg::MODE_DPIN &&
      !st_reg.cfg[gcsc_pkg::DP_CORNER]);
  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  // Error for unmapped access or a locked configuration write
  assign pslverr = access && (!hit || (cfgWrite && userMode));

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Configuration must not move during user mode
  chk_cfg_locked: assert property (
    (ce && userMode) |=> $stable(st_reg.cfg))
    else $error("configuration changed in user mode");

  // Enable changes only at a falling edge of the chosen source
  chk_gate_edge: assert property (
    !$stable(st_reg.gateEn) |-> $past(st_reg.prevSrc && !srcLvl && ce))
    else $error("enable taken away from a falling edge");

  // Network high only while the gate was open a cycle before
  chk_net_gated: assert property (
    st_reg.netOut |-> $past(st_reg.gateEn))
    else $error("network high with gate closed");

  // Static off bit holds the network down after the next fall
  chk_net_off: assert property (
    (ce && st_reg.cfg[gcsc_pkg::NET_OFF] && st_reg.prevSrc && !srcLvl)
    |=> !st_reg.gateEn)
    else $error("network not powered down");

  // PLL feed only from pins or PLL outputs
  chk_feed_source: assert property (
    st_reg.feedOut |-> $past(mode == gcsc_pkg::MODE_DYN))
    else $error("PLL fed from a barred source");

  // Internal logic source never reaches a PLL input
  chk_logic_barred: assert property (
    (ce && mode == gcsc_pkg::MODE_LOGIC) |=> !st_reg.feedOut)
    else $error("internal logic source fed a PLL");

  // Code 00 routes pin zero to the network when the gate is open
  chk_sel_pin0: assert property (
    (ce && mode == gcsc_pkg::MODE_DYN && dynSel == 2'h0 && st_reg.gateEn)
    |=> st_reg.netOut == $past(pinLvl[0]))
    else $error("select code 00 did not route pin zero");

  // Left-side blocks never see pin activity
  chk_left_side: assert property (
    LEFT_SIDE |-> (clkPinGpio == 2'h0))
    else $error("left-side block shows pin input");

  // Reference clock follows the switch control within one cycle
  chk_pll_ref: assert property (
    ce |=> st_reg.refOut == $past(!LEFT_SIDE && st_reg.filt[
      gcsc_pkg::PIN_LSB + int'(st_reg.cfg[gcsc_pkg::SW_DYNAMIC]
        ? clkSwitch : st_reg.cfg[gcsc_pkg::SW_STATIC])]))
    else $error("PLL reference mux wrong");

  // Pin levels move only once stages two and three agree
  chk_sync_pins: assert property (
    (ce && !LEFT_SIDE &&
     st_reg.s2[gcsc_pkg::PIN_LSB +: 2] == st_reg.s3[gcsc_pkg::PIN_LSB +: 2])
    |=> clkPinGpio == $past(st_reg.s2[gcsc_pkg::PIN_LSB +: 2]))
    else $error("pin level passed an unsettled synchroniser");

  // Code 01 routes pin one to the network when the gate is open
  chk_sel_pin1: assert property (
    (ce && mode == gcsc_pkg::MODE_DYN && dynSel == 2'h1 && st_reg.gateEn)
    |=> st_reg.netOut == $past(pinLvl[1]))
    else $error("select code 01 did not route pin one");

  // Code 10 routes the first chosen PLL tap
  chk_sel_tap0: assert property (
    (ce && mode == gcsc_pkg::MODE_DYN && dynSel == 2'h2 && st_reg.gateEn)
    |=> st_reg.netOut == $past(st_reg.filt[
      (st_reg.cfg[gcsc_pkg::PICK0_LSB + 1]
        ? gcsc_pkg::PLLB_LSB : gcsc_pkg::PLLA_LSB)
      + int'(st_reg.cfg[gcsc_pkg::PICK0_LSB])]))
    else $error("select code 10 did not route tap zero");

  // Code 11 routes the second chosen PLL tap
  chk_sel_tap1: assert property (
    (ce && mode == gcsc_pkg::MODE_DYN && dynSel == 2'h3 && st_reg.gateEn)
    |=> st_reg.netOut == $past(st_reg.filt[
      (st_reg.cfg[gcsc_pkg::PICK1_LSB + 1]
        ? gcsc_pkg::PLLB_LSB : gcsc_pkg::PLLA_LSB)
      + int'(st_reg.cfg[gcsc_pkg::PICK1_LSB])]))
    else $error("select code 11 did not route tap one");

  // Logic source reaches the network whatever the select says
  chk_logic_route: assert property (
    (ce && mode == gcsc_pkg::MODE_LOGIC && st_reg.gateEn)
    |=> st_reg.netOut == $past(logicSrc))
    else $error("logic source not routed");

  // Dual-purpose mode takes the picked corner pin or the plain pin
  chk_dual_route: assert property (
    (ce && mode == gcsc_pkg::MODE_DPIN && st_reg.gateEn)
    |=> st_reg.netOut == $past(st_reg.cfg[gcsc_pkg::DP_CORNER]
      ? st_reg.filt[gcsc_pkg::CORNER_LSB
          + int'(st_reg.cfg[gcsc_pkg::CORNER_PICK])]
      : st_reg.filt[gcsc_pkg::DP_BIT]))
    else $error("dual-purpose source not routed");

  // No source selected keeps the network quiet
  chk_none_quiet: assert property (
    (ce && mode == gcsc_pkg::MODE_NONE) |=> !st_reg.netOut)
    else $error("network active with no source");

  // Pad stays an input while it is the network source
  chk_dp_no_fight: assert property (
    (mode == gcsc_pkg::MODE_DPIN && !st_reg.cfg[gcsc_pkg::DP_CORNER])
    |-> !dpOe)
    else $error("pad driven while used as source");

  // Locked configuration write is answered with an error
  chk_err_locked: assert property (
    (psel && penable && pwrite && paddr == gcsc_pkg::CFG_OFF && userMode)
    |-> pslverr)
    else $error("locked write not refused");

  // Gate opens only while the enable asks for it
  chk_gate_open: assert property (
    $rose(st_reg.gateEn) |->
      $past(netEnable && !st_reg.cfg[gcsc_pkg::NET_OFF]))
    else $error("gate opened without enable");

  // Pins and PLL taps let the PLL copy track the network
  chk_feed_follows: assert property (
    (ce && mode == gcsc_pkg::MODE_DYN) |=> pllFeed == globalNet)
    else $error("PLL copy differs from network");

  // Dual-purpose pin source never reaches a PLL input
  chk_feed_dpin: assert property (
    (ce && mode == gcsc_pkg::MODE_DPIN) |=> !st_reg.feedOut)
    else $error("dual-purpose source fed a PLL");

endmodule

// *** include/gcsc_pkg.sv ***
// Constants for the global clock source control block
package gcsc_pkg;

  // Register byte offsets on the APB port
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] LEVEL_OFF = 8'h08;

  // Synchronised source vector layout
  localparam int SYNC_W = 15;
  localparam int PIN_LSB = 0;
  localparam int DP_BIT = 2;
  localparam int CORNER_LSB = 3;
  localparam int PLLA_LSB = 5;
  localparam int PLLB_LSB = 10;
  localparam int PLL_OUTS = 5;

  // Static configuration register fields
  localparam int CFG_W = 13;
  localparam logic [12:0] CFG_RESET = 13'h0000;
  localparam int MODE_LSB = 0;
  localparam int CORNER_PICK = 2;
  localparam int PICK0_LSB = 3;
  localparam int PICK1_LSB = 5;
  localparam int SW_STATIC = 7;
  localparam int SW_DYNAMIC = 8;
  localparam int NET_OFF = 9;
  localparam int DP_DRIVE = 10;
  localparam int DP_VALUE = 11;
  localparam int DP_CORNER = 12;

  // Status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_GATE = 2;
  localparam int ST_NET = 3;
  localparam int ST_FEED_OK = 4;
  localparam int ST_USER = 5;
  localparam int ST_REF = 6;
  localparam int ST_INDEX_LSB = 7;

  // Source modes held in the configuration register
  typedef enum logic [1:0] {
    MODE_DYN = 2'h0,
    MODE_DPIN = 2'h1,
    MODE_LOGIC = 2'h2,
    MODE_NONE = 2'h3
  } gcsc_mode_t;

  // Network counts per device variant
  localparam int NET_COUNT_GX = 30;
  localparam int NET_COUNT_E = 20;
  localparam int NET_COUNT_SMALL = 10;

endpackage

// *** sim/gcsc_clock_control_test.sv ***
// Self-checking bench for the clock source control block
`timescale 1ns/1ps
module gcsc_clock_control_test;
  localparam int NET_IDX = 5;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdData, cfg;
  logic [1:0] dynSel = 2'h0, clkPin, cornerPin, clkPinGpio;
  logic netEnable = 1'b0, clkSwitch = 1'b0, userMode = 1'b0;
  logic dpOut, dpOe, dpLvl, dpWire, logicSrc, globalNet, pllFeed;
  logic pllRef, cornerGpio, rdErr;
  logic [4:0] pllAOut, pllBOut;
  logic [2:0] phase;
  logic [15:0] lfsr = 16'hC93C;
  int errTotal = 0, nChecks = 0, cycles = 0;
  // Shared pin: our drive wins over the far-side level
  assign dpWire = dpOe ? dpOut : dpLvl;
  gcsc_src_model i_gcsc_src_model (.core_clk(core_clk), .rst(rst),
    .phase(phase), .clkPin(clkPin), .dpLvl(dpLvl), .cornerPin(cornerPin),
    .pllAOut(pllAOut), .pllBOut(pllBOut), .logicSrc(logicSrc));
  gcsc_clock_control #(.NET_INDEX(NET_IDX)) i_gcsc_clock_control (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .clkPin(clkPin),
    .dpIn(dpWire), .dpOut(dpOut), .dpOe(dpOe), .cornerPin(cornerPin),
    .pllAOut(pllAOut), .pllBOut(pllBOut), .logicSrc(logicSrc),
    .dynSel(dynSel), .netEnable(netEnable), .clkSwitch(clkSwitch),
    .userMode(userMode), .globalNet(globalNet), .pllFeed(pllFeed),
    .pllRef(pllRef), .clkPinGpio(clkPinGpio), .cornerGpio(cornerGpio),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #20 core_clk = ~core_clk;
  // Hang guard, well above the planned run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      errTotal++;
      stopTest();
    end
  end
  task automatic check(logic [31:0] seen, logic [31:0] want);
    nChecks++;
    if (seen !== want) begin
      errTotal++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask
  task automatic stopTest();
    $display("Checks %0d, mismatches %0d", nChecks, errTotal);
    if (errTotal == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // One APB transfer, held until pready is seen high
  task automatic apb(logic [7:0] a, logic w, logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic setCfg(logic [31:0] c);
    cfg = c;
    apb(gcsc_pkg::CFG_OFF, 1'b1, c);
    check(32'(rdErr), 32'h0);
  endtask
  function automatic logic tap(logic [1:0] i);
    return i[1] ? pllBOut[i[0]] : pllAOut[i[0]];
  endfunction
  // Expected network source mux with both power-down paths
  function automatic logic expNet(logic en);
    logic v;
    case (cfg[1:0])
      2'h0: v = dynSel[1] ? tap(dynSel[0] ? cfg[6:5] : cfg[4:3])
        : clkPin[dynSel[0]];
      2'h1: v = cfg[12] ? cornerPin[cfg[2]] : dpWire;
      2'h2: v = logicSrc;
      default: v = 1'b0;
    endcase
    return v & en & !cfg[9];
  endfunction
  // Settle past sync and gate, then sample late in each phase
  task automatic run(logic en);
    logic v;
    clkSwitch <= ^rnd();
    repeat (300) @(posedge core_clk);
    repeat (12) begin
      do @(posedge core_clk); while (phase !== 3'h7);
      v = expNet(en);
      check(32'(globalNet), 32'(v));
      check(32'(pllFeed), 32'(v & (cfg[1:0] == 2'h0)));
      check(32'(pllRef), 32'(clkPin[cfg[8] ? clkSwitch : cfg[7]]));
      check(32'(clkPinGpio), 32'(clkPin));
      check(32'(cornerGpio), 32'(cornerPin[!cfg[2]]));
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(gcsc_pkg::CFG_OFF, 1'b0, 32'h0);
    check(rdData, 32'(gcsc_pkg::CFG_RESET));
    apb(gcsc_pkg::STATUS_OFF, 1'b0, 32'h0);
    check(32'(rdData[11:7]), 32'(NET_IDX));
    apb(8'h0C, 1'b0, 32'h0);
    check(rdData, 32'h0);
    check(32'(rdErr), 32'h1);
    apb(gcsc_pkg::LEVEL_OFF, 1'b1, 32'hFFFFFFFF);
    check(32'(rdErr), 32'h0);
    $display("Test registers done");
    // Every code; enable dropped around each switch
    for (int s = 0; s < 4; s++) begin
      setCfg(32'(rnd()) & 32'h1F8);
      netEnable <= 1'b0;
      @(posedge core_clk);
      dynSel <= 2'(s);
      repeat (20) @(posedge core_clk);
      netEnable <= 1'b1;
      run(1'b1);
    end
    $display("Test dynamic select done");
    // Static-only sources ignore the select and never feed a PLL
    for (int m = 1; m < 4; m++) begin
      setCfg((32'(rnd()) & 32'h1004) | 32'(m));
      dynSel <= 2'(rnd());
      run(1'b1);
    end
    setCfg(32'h0);
    netEnable <= 1'b0;
    run(1'b0);
    setCfg(32'h200);
    netEnable <= 1'b1;
    run(1'b1);
    $display("Test modes and power-down done");
    setCfg(32'hC00);
    check(32'({dpOe, dpOut}), 32'h3);
    repeat (4) @(posedge core_clk);
    apb(gcsc_pkg::LEVEL_OFF, 1'b0, 32'h0);
    check(32'(rdData[gcsc_pkg::DP_BIT]), 32'h1);
    userMode <= 1'b1;
    apb(gcsc_pkg::CFG_OFF, 1'b1, 32'h2);
    check(32'(rdErr), 32'h1);
    apb(gcsc_pkg::CFG_OFF, 1'b0, 32'h0);
    check(rdData, 32'hC00);
    apb(gcsc_pkg::STATUS_OFF, 1'b0, 32'h0);
    check(32'(rdData[gcsc_pkg::ST_USER]), 32'h1);
    // Mid-run reset drops the configuration and closes the gate
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(32'(globalNet), 32'h0);
    apb(gcsc_pkg::CFG_OFF, 1'b0, 32'h0);
    check(rdData, 32'(gcsc_pkg::CFG_RESET));
    $display("Test pin drive and lock done");
    stopTest();
  end
endmodule

// *** sim/gcsc_src_model.sv ***
// Far-side model: clock pins, two PLLs, dual pin, fabric logic
`timescale 1ns/1ps
module gcsc_src_model (
  input wire logic core_clk,
  input wire logic rst,
  output logic [2:0] phase,
  output logic [1:0] clkPin,
  output logic dpLvl,
  output logic [1:0] cornerPin,
  output logic [4:0] pllAOut,
  output logic [4:0] pllBOut,
  output logic logicSrc
);
  logic [7:0] cntReg;
  // Sources move only as phase wraps, so mid-phase samples are safe
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cntReg <= 8'h00;
    end else begin
      cntReg <= cntReg + 8'h01;
    end
  end
  // Distinct waveforms so every selectable source can be told apart
  assign phase = cntReg[2:0];
  assign clkPin = cntReg[4:3];
  assign dpLvl = cntReg[5] ^ cntReg[3];
  assign cornerPin = {cntReg[7] ^ cntReg[3], cntReg[6] ^ cntReg[4]};
  assign pllAOut = {cntReg[7:5], cntReg[6:5]};
  assign pllBOut = {~cntReg[5:3], cntReg[7], ~cntReg[5]};
  assign logicSrc = cntReg[7] ^ cntReg[4];
endmodule
